// ===== rtl/smp_kw_match.sv
// Case-blind keyword lookup against the long and short spellings
`timescale 1ns/1ps
module smp_kw_match
  import smp_pkg::*;
(
  input wire logic [KW_MAX-1:0][7:0] kw_in,
  input wire logic [3:0] len_in,
  output logic hit_out,
  output smp_kw_t id_out
);

  // ----------------------------------------------------------------------
  // Per-keyword compare
  // ----------------------------------------------------------------------
  logic [KW_NUM-1:0] eq; // One bit per table entry

  for (genvar k = 0; k < KW_NUM; k++) begin : g_kw
    logic eq_b;
    // Only the exact long or short length is legal; other cuts miss
    always_comb begin
      eq_b = (len_in != 4'h0) &&
             (len_in == KW_LONG[k] || len_in == KW_SHORT[k]);
      for (int i = 0; i < KW_MAX; i++) begin
        // Bytes past this entry's long spelling are never indexed
        if (4'(i) < len_in && 4'(i) < KW_LONG[k]) begin
          // Text is right aligned, so char i sits long-1-i bytes up
          if (to_upper(kw_in[i]) !=
              KW_TEXT[k][8*(int'(KW_LONG[k])-1-i) +: 8]) begin
            eq_b = 1'b0;
          end
        end
      end
    end
    assign eq[k] = eq_b;
  end

  // ----------------------------------------------------------------------
  // Encode; spellings are unique so at most one entry hits
  // ----------------------------------------------------------------------
  always_comb begin
    hit_out = 1'b0;
    id_out = 4'h0;
    for (int k = 0; k < KW_NUM; k++) begin
      if (eq[k]) begin
        hit_out = 1'b1;
        id_out = 4'(k);
      end
    end
  end

endmodule // smp_kw_match

// ===== rtl/smp_parser.sv
// Command message parser: splits units, tracks the path, flags errors
`timescale 1ns/1ps

module smp_parser
  import smp_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] char_in,
  input wire logic char_valid_in,
  input wire logic eoi_in,
  input wire logic resp_pending_in,
  output logic unit_valid_out,
  output smp_unit_s unit_out,
  output smp_node_t path_out,
  output logic qint_err_out,
  output logic resp_flush_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_UNIT,    // Waiting for the first character of a unit
    ST_KW,      // Collecting a keyword
    ST_COMMON,  // Collecting common command letters
    ST_AFTQ,    // Just after a query mark
    ST_PARAM,   // In the parameter list
    ST_SKIP     // Error seen, drop until the unit ends
  } smp_state_e;

  smp_state_e state_r, state_nxt;
  logic [KW_MAX-1:0][7:0] kwbuf_r, kwbuf_nxt; // Keyword text so far
  logic [3:0] kwlen_r, kwlen_nxt;             // Keyword length
  smp_node_t cur_r, cur_nxt;                  // Node reached so far
  smp_node_t prev_r, prev_nxt;                // Node before last keyword
  smp_node_t path_r, path_nxt;                // Inherited command path
  logic msg_start_r, msg_start_nxt;           // Next char opens message
  logic query_r, query_nxt;
  logic common_r, common_nxt;
  logic [23:0] mnem_r, mnem_nxt;
  logic [1:0] mlen_r, mlen_nxt;               // Common letters seen
  logic [3:0] nparam_r, nparam_nxt;
  logic pchars_r, pchars_nxt;                 // Current parameter not empty
  smp_err_e err_r, err_nxt;
  smp_unit_s unit_r, unit_nxt;
  logic unit_valid_r, unit_valid_nxt;
  logic qint_r, qint_nxt;
  logic flush_r, flush_nxt;

  // Decode of the incoming character
  logic term;      // Message terminator on this character
  logic sep;       // Unit ends on this character
  logic end_unit;  // A unit ends on this character, emitted the next cycle
  logic do_res;    // Resolve the collected keyword
  logic [KW_MAX-1:0][7:0] kw_cand;
  logic [3:0] len_cand;
  logic kw_hit;
  smp_kw_t kw_id;
  logic [4:0] res;  // Found flag and node

  // ----------------------------------------------------------------------
  // Tree walk helpers
  // ----------------------------------------------------------------------
  // Parent p is reachable from c directly or across up to two optional
  // levels; deeper optional chains do not exist in this tree.
  function automatic logic reach(input smp_node_t p, input smp_node_t c);
    smp_node_t pp;
    pp = NODE_PAR[p];
    return (p == c) ||
           (NODE_OPT[p] && (pp == c ||
            (NODE_OPT[pp] && NODE_PAR[pp] == c)));
  endfunction

  // Child of c carrying keyword k, skipping optional levels
  function automatic logic [4:0] resolve(input smp_node_t c,
                                         input smp_kw_t k);
    logic [4:0] r;
    r = 5'h00;
    for (int n = 1; n < NODE_NUM; n++) begin
      if (!r[4] && NODE_KW[n] == k && reach(NODE_PAR[n], c)) begin
        r = {1'b1, 4'(n)};
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Keyword candidate: buffer plus this letter
  // ----------------------------------------------------------------------
  // A letter that carries the end signal must still be part of the
  // keyword, so lookup sees the appended text, not the stored one.
  always_comb begin
    kw_cand = kwbuf_r;
    len_cand = kwlen_r;
    if (char_valid_in && state_r == ST_KW && is_letter(char_in) &&
        kwlen_r < 4'(KW_MAX)) begin
      kw_cand[kwlen_r] = char_in;
      len_cand = kwlen_r + 4'h1;
    end
  end

  smp_kw_match u_kw (
    .kw_in(kw_cand),
    .len_in(len_cand),
    .hit_out(kw_hit),
    .id_out(kw_id)
  );

  assign res = resolve(cur_r, kw_id);
  assign term = char_valid_in && (char_in == CH_NL || eoi_in);
  assign sep = (char_in == CH_SEMI) || term;

  // ----------------------------------------------------------------------
  // Next state of the parser
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    kwbuf_nxt = kw_cand;
    kwlen_nxt = len_cand;
    cur_nxt = cur_r;
    prev_nxt = prev_r;
    path_nxt = path_r;
    msg_start_nxt = msg_start_r;
    query_nxt = query_r;
    common_nxt = common_r;
    mnem_nxt = mnem_r;
    mlen_nxt = mlen_r;
    nparam_nxt = nparam_r;
    pchars_nxt = pchars_r;
    err_nxt = err_r;
    unit_nxt = unit_r;
    unit_valid_nxt = 1'b0;
    qint_nxt = 1'b0;
    flush_nxt = 1'b0;
    do_res = 1'b0;
    end_unit = 1'b0;
    if (char_valid_in) begin
      // First character of a message while a reply is still unread
      if (msg_start_r) begin
        msg_start_nxt = 1'b0;
        if (resp_pending_in) begin
          qint_nxt = 1'b1;
          flush_nxt = 1'b1;
        end
      end
      unique case (state_r)
        ST_UNIT: begin
          if (char_in == CH_COLON) begin
            cur_nxt = ROOT_NODE;
            state_nxt = ST_KW;
          end else if (char_in == CH_STAR) begin
            common_nxt = 1'b1;
            state_nxt = ST_COMMON;
          end else if (is_letter(char_in)) begin
            cur_nxt = path_r;
            kwbuf_nxt[0] = char_in;
            kwlen_nxt = 4'h1;
            state_nxt = ST_KW;
            // A lone letter ending the message is no keyword
            if (term) begin
              err_nxt = ERR_HEADER;
            end
          end else if (!sep && char_in != CH_SPACE) begin
            // Notation brackets and bars land here as well
            err_nxt = ERR_SYNTAX;
            state_nxt = ST_SKIP;
          end
        end
        ST_KW: begin
          if (sep || char_in == CH_COLON || char_in == CH_SPACE ||
              char_in == CH_QUERY) begin
            do_res = 1'b1;
            if (char_in == CH_COLON) begin
              kwlen_nxt = 4'h0;
            end
            if (char_in == CH_SPACE) begin
              state_nxt = ST_PARAM;
            end
            if (char_in == CH_QUERY) begin
              query_nxt = 1'b1;
              state_nxt = ST_AFTQ;
            end
          end else if (is_letter(char_in)) begin
            // Longer than any spelling: cannot match
            if (kwlen_r == 4'(KW_MAX)) begin
              err_nxt = ERR_HEADER;
              state_nxt = ST_SKIP;
            end
          end else begin
            err_nxt = ERR_SYNTAX;
            state_nxt = ST_SKIP;
          end
        end
        ST_COMMON: begin
          if (is_letter(char_in) && mlen_r < MNEM_LEN) begin
            mnem_nxt = {mnem_r[15:0], to_upper(char_in)};
            mlen_nxt = mlen_r + 2'h1;
          end else if (mlen_r != MNEM_LEN) begin
            err_nxt = ERR_SYNTAX;
            state_nxt = ST_SKIP;
          end else if (char_in == CH_QUERY) begin
            query_nxt = 1'b1;
            state_nxt = ST_AFTQ;
          end else if (char_in == CH_SPACE) begin
            state_nxt = ST_PARAM;
          end else if (!sep) begin
            err_nxt = ERR_SYNTAX;
            state_nxt = ST_SKIP;
          end
        end
        ST_AFTQ: begin
          // Only a blank or the end of the unit may follow the mark
          if (char_in == CH_SPACE) begin
            state_nxt = ST_PARAM;
          end else if (!sep) begin
            err_nxt = ERR_SYNTAX;
            state_nxt = ST_SKIP;
          end
        end
        ST_PARAM: begin
          if (char_in == CH_COMMA) begin
            if (!pchars_r) begin
              err_nxt = ERR_SYNTAX;
              state_nxt = ST_SKIP;
            end else begin
              if (nparam_r != NPARAM_MAX) begin
                nparam_nxt = nparam_r + 4'h1;
              end
              pchars_nxt = 1'b0;
            end
          end else if (char_in != CH_SPACE && char_in != CH_NL &&
                       char_in != CH_SEMI) begin
            // Parameter text is not interpreted here
            pchars_nxt = 1'b1;
          end
        end
        ST_SKIP: begin
          // Drop characters until the unit boundary
        end
      endcase

      // Keyword lookup and tree step
      if (do_res) begin
        if (len_cand == 4'h0) begin
          err_nxt = ERR_SYNTAX;
        end else if (!kw_hit) begin
          err_nxt = ERR_HEADER;
        end else if (!res[4]) begin
          err_nxt = ERR_PATH;
        end else begin
          prev_nxt = cur_r;
          cur_nxt = res[3:0];
        end
        if (err_nxt != ERR_NONE) begin
          state_nxt = ST_SKIP;
        end
      end

      // Unit boundary; empty units between separators are dropped
      end_unit = sep && (state_r != ST_UNIT || err_nxt != ERR_NONE);
      if (end_unit) begin
        if (state_r == ST_PARAM) begin
          if (pchars_nxt && nparam_nxt != NPARAM_MAX) begin
            nparam_nxt = nparam_nxt + 4'h1;
          end else if (!pchars_nxt) begin
            err_nxt = ERR_SYNTAX;
          end
        end
        unit_nxt.common = common_nxt;
        unit_nxt.query = query_nxt;
        unit_nxt.err = err_nxt;
        unit_nxt.node = common_nxt ? ROOT_NODE : cur_nxt;
        unit_nxt.nparam = nparam_nxt;
        unit_nxt.mnem = common_nxt ? mnem_nxt : 24'h00_0000;
        unit_valid_nxt = 1'b1;
        if (!common_nxt && err_nxt == ERR_NONE) begin
          path_nxt = prev_nxt;
        end
        // Common units fall through with the path untouched
        state_nxt = ST_UNIT;
        kwlen_nxt = 4'h0;
        query_nxt = 1'b0;
        common_nxt = 1'b0;
        mlen_nxt = 2'h0;
        mnem_nxt = 24'h00_0000;
        nparam_nxt = 4'h0;
        pchars_nxt = 1'b0;
        err_nxt = ERR_NONE;
      end
      if (term) begin
        state_nxt = ST_UNIT;
        path_nxt = ROOT_NODE;
        msg_start_nxt = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Parser registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_r <= ST_UNIT;
      kwbuf_r <= '0;
      kwlen_r <= 4'h0;
      cur_r <= ROOT_NODE;
      prev_r <= ROOT_NODE;
      path_r <= ROOT_NODE;
      msg_start_r <= 1'b1;
      query_r <= 1'b0;
      common_r <= 1'b0;
      mnem_r <= 24'h00_0000;
      mlen_r <= 2'h0;
      nparam_r <= 4'h0;
      pchars_r <= 1'b0;
      err_r <= ERR_NONE;
      unit_r <= '0;
      unit_valid_r <= 1'b0;
      qint_r <= 1'b0;
      flush_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kwbuf_r <= kwbuf_nxt;
      kwlen_r <= kwlen_nxt;
      cur_r <= cur_nxt;
      prev_r <= prev_nxt;
      path_r <= path_nxt;
      msg_start_r <= msg_start_nxt;
      query_r <= query_nxt;
      common_r <= common_nxt;
      mnem_r <= mnem_nxt;
      mlen_r <= mlen_nxt;
      nparam_r <= nparam_nxt;
      pchars_r <= pchars_nxt;
      err_r <= err_nxt;
      unit_r <= unit_nxt;
      unit_valid_r <= unit_valid_nxt;
      qint_r <= qint_nxt;
      flush_r <= flush_nxt;
    end
  end

  assign unit_valid_out = unit_valid_r;
  assign unit_out = unit_r;
  assign path_out = path_r;
  assign qint_err_out = qint_r;
  assign resp_flush_out = flush_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  AST_SEMI_ENDS: assert property (
    (char_valid_in && char_in == CH_SEMI && state_r != ST_UNIT)
    |=> unit_valid_out) else $error("semicolon did not end unit");
  AST_TERM_CLEARS_PATH: assert property (
    term |=> (path_r == ROOT_NODE) && msg_start_r)
    else $error("path not empty after terminator");
  AST_PATH_INHERIT: assert property (
    (char_valid_in && char_in == CH_SEMI && state_r == ST_PARAM &&
     pchars_r && err_r == ERR_NONE && !common_r)
    |=> path_r == $past(prev_r)) else $error("path not inherited");
  AST_PATH_ERR: assert property (
    (char_valid_in && char_in == CH_SEMI && state_r == ST_KW &&
     len_cand != 4'h0 && kw_hit && !res[4])
    |=> unit_valid_out && unit_out.err == ERR_PATH)
    else $error("bad keyword chain not flagged");
  AST_ROOT_COLON: assert property (
    (char_valid_in && !term && state_r == ST_UNIT && char_in == CH_COLON)
    |=> cur_r == ROOT_NODE && state_r == ST_KW)
    else $error("leading colon did not restart at root");
  AST_BAD_SPELLING: assert property (
    (char_valid_in && char_in == CH_SEMI && state_r == ST_KW &&
     len_cand != 4'h0 && !kw_hit)
    |=> unit_out.err == ERR_HEADER) else $error("bad spelling passed");
  AST_QUERY_FLAG: assert property (
    (char_valid_in && state_r == ST_KW && char_in == CH_QUERY && !term)
    ##1 (char_valid_in && char_in == CH_SEMI)
    |=> unit_valid_out && unit_out.query)
    else $error("query mark not reported");
  AST_QUERY_INTERRUPT: assert property (
    (char_valid_in && msg_start_r && resp_pending_in)
    |=> qint_err_out && resp_flush_out)
    else $error("unread reply not flagged");
  AST_COMMON_OK: assert property (
    (char_valid_in && state_r == ST_COMMON && mlen_r == MNEM_LEN &&
     char_in == CH_SEMI)
    |=> unit_valid_out && unit_out.common && unit_out.err == ERR_NONE)
    else $error("common command not recognised");
  AST_COMMON_PATH: assert property (
    (char_valid_in && char_in == CH_SEMI && common_r && !term)
    |=> $stable(path_r)) else $error("common command moved path");

endmodule // smp_parser

// ===== rtl/smp_pkg.sv
// Shared constants, keyword tree and types of the command message parser
package smp_pkg;

  // ----------------------------------------------------------------------
  // Character codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CH_NL = 8'h0A;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_QUERY = 8'h3F;
  localparam logic [7:0] CH_LBRACK = 8'h5B;
  localparam logic [7:0] CH_LOW_A = 8'h61;
  localparam logic [7:0] CH_LOW_Z = 8'h7A;
  localparam logic [7:0] CH_UP_A = 8'h41;
  localparam logic [7:0] CH_UP_Z = 8'h5A;
  localparam logic [7:0] CASE_BIT = 8'h20;

  // ----------------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------------
  localparam int KW_MAX = 10;               // Longest keyword spelling
  localparam int KW_NUM = 10;               // Keywords known to the tree
  localparam int NODE_NUM = 16;             // Tree nodes, node 0 is root
  localparam logic [1:0] MNEM_LEN = 2'h3;   // Common command letters
  localparam logic [3:0] ROOT_NODE = 4'h0;  // Empty path
  localparam logic [3:0] NPARAM_MAX = 4'hF; // Parameter count saturates

  typedef logic [3:0] smp_node_t;
  typedef logic [3:0] smp_kw_t;

  // ----------------------------------------------------------------------
  // Keyword spellings: long form, long length, short length
  // ----------------------------------------------------------------------
  localparam logic [79:0] KW_TEXT [KW_NUM] = '{
    "SOURCE", "CURRENT", "VOLTAGE", "LEVEL", "IMMEDIATE",
    "TRIGGERED", "PROTECTION", "OUTPUT", "STATE", "CLEAR"};
  localparam logic [3:0] KW_LONG [KW_NUM] = '{
    4'h6, 4'h7, 4'h7, 4'h5, 4'h9, 4'h9, 4'hA, 4'h6, 4'h5, 4'h5};
  localparam logic [3:0] KW_SHORT [KW_NUM] = '{
    4'h4, 4'h4, 4'h4, 4'h3, 4'h3, 4'h4, 4'h4, 4'h4, 4'h4, 4'h3};

  // ----------------------------------------------------------------------
  // Command tree: keyword, parent node and optional flag per node
  // ----------------------------------------------------------------------
  localparam logic [3:0] NODE_KW [NODE_NUM] = '{
    4'h0, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
    4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h6, 4'h9};
  localparam logic [3:0] NODE_PAR [NODE_NUM] = '{
    4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h4, 4'h4, 4'h2,
    4'h3, 4'h8, 4'h8, 4'h3, 4'h0, 4'hC, 4'hC, 4'hE};
  localparam logic NODE_OPT [NODE_NUM] = '{
    1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0,
    1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ERR_NONE,    // Unit parsed cleanly
    ERR_SYNTAX,  // Misplaced character or empty field
    ERR_HEADER,  // Keyword not a known long or short spelling
    ERR_PATH     // Keywords do not chain in the tree
  } smp_err_e;

  typedef struct packed {
    logic common;        // Unit is a common command
    logic query;         // Unit carries a query mark
    smp_err_e err;       // Error found in the unit
    smp_node_t node;     // Resolved tree node, root for common
    logic [3:0] nparam;  // Parameters seen
    logic [23:0] mnem;   // Common command letters, upper case
  } smp_unit_s;

  // ----------------------------------------------------------------------
  // Character helpers
  // ----------------------------------------------------------------------
  function automatic logic is_letter(input logic [7:0] ch);
    return (ch >= CH_UP_A && ch <= CH_UP_Z) ||
           (ch >= CH_LOW_A && ch <= CH_LOW_Z);
  endfunction

  function automatic logic [7:0] to_upper(input logic [7:0] ch);
    return (ch >= CH_LOW_A && ch <= CH_LOW_Z) ? (ch & ~CASE_BIT) : ch;
  endfunction

endpackage

// ===== verif/scpi_message_parser_tb_top.sv
// Self-checking bench of the command message parser
`timescale 1ns/1ps
module scpi_message_parser_tb_top;
  import smp_pkg::*;
  // ----------------------------------------------------------------------
  // Clock, reset and wiring
  // ----------------------------------------------------------------------
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] ch;
  logic vld, eoi, pend, uv, qint, flush;
  smp_unit_s uo; // Unit fields seen
  smp_node_t po; // Inherited path seen
  smp_unit_s got_q[$]; // Units in arrival order
  smp_node_t path_q[$]; // Path beside each unit
  int n_fail = 0;
  int compares = 0;
  int n_qint = 0;
  int cyc = 0;

  always #50 clk_in = ~clk_in;

  smp_host u_host (.clk_in(clk_in), .char_out(ch), .valid_out(vld),
    .eoi_out(eoi), .pend_out(pend));
  smp_parser u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .char_in(ch),
    .char_valid_in(vld), .eoi_in(eoi), .resp_pending_in(pend),
    .unit_valid_out(uv), .unit_out(uo), .path_out(po),
    .qint_err_out(qint), .resp_flush_out(flush));

  // Pulses are sampled mid-cycle, well clear of the launching edge
  always @(negedge clk_in) begin
    cyc <= cyc + 1;
    if (uv === 1'b1) begin
      got_q.push_back(uo);
      path_q.push_back(po);
    end
    if (qint === 1'b1) n_qint++;
    if (qint !== flush) begin
      n_fail++;
      $display("BAD flush exp %b got %b", qint, flush);
    end
    if (cyc == 3000) begin // Hang guard
      n_fail++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [35:0] e,
                     input logic [35:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask

  function automatic smp_unit_s mk(logic c, logic q, smp_err_e e,
      smp_node_t n, logic [3:0] np, logic [23:0] m);
    mk = '{c, q, e, n, np, m};
  endfunction

  // Full compare, or the error code only where other fields are loose
  task automatic chk_u(input int i, input smp_unit_s e, input bit full);
    if (full) chk("unit", e, got_q[i]);
    else chk("err", e.err, got_q[i].err);
  endtask

  // Send one message and expect a count of units back
  task automatic run(input string s, input bit with_eoi, input int n);
    got_q.delete();
    path_q.delete();
    u_host.send(s, with_eoi);
    repeat (4) @(negedge clk_in);
    chk("units", n, got_q.size());
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_chain();
    run("VOLT:LEV 7;PROT 1\n", 1'b0, 2);
    chk_u(0, mk(0, 0, ERR_NONE, 4'h8, 4'h1, 24'h0), 1);
    chk("path", 4'h3, path_q[0]);
    chk_u(1, mk(0, 0, ERR_NONE, 4'hB, 4'h1, 24'h0), 1);
    chk("path", 4'h0, path_q[1]);
    $display("t_chain done");
  endtask

  task automatic t_root();
    run("OUTP:STAT 1;OUTP:PROT:CLE;:OUTP:PROT:CLE\n", 1'b0, 3);
    chk_u(0, mk(0, 0, ERR_NONE, 4'hD, 4'h1, 24'h0), 1);
    chk_u(1, mk(0, 0, ERR_PATH, 4'h0, 4'h0, 24'h0), 0);
    chk("path", 4'hC, path_q[1]);
    chk_u(2, mk(0, 0, ERR_NONE, 4'hF, 4'h0, 24'h0), 1);
    $display("t_root done");
  endtask

  task automatic t_spell();
    string s[7] = '{"volt 1\n", "VOLTAGE 1\n", "VoLtAgE 1\n",
      "sour:volt 1\n", "CURR:TRIG 1\n", "VOL 1\n", "VOLTAG 1\n"};
    smp_node_t nd[5] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h6};
    for (int i = 0; i < 5; i++) begin
      run(s[i], 1'b0, 1);
      chk_u(0, mk(0, 0, ERR_NONE, nd[i], 4'h1, 24'h0), 1);
    end
    for (int i = 5; i < 7; i++) begin
      run(s[i], 1'b0, 1);
      chk_u(0, mk(0, 0, ERR_HEADER, 4'h0, 4'h0, 24'h0), 0);
    end
    $display("t_spell done");
  endtask

  task automatic t_query();
    run("VOLT:TRIG? 5\n", 1'b0, 1);
    chk_u(0, mk(0, 1, ERR_NONE, 4'hA, 4'h1, 24'h0), 1);
    run("OUTP:STAT 1,0\n", 1'b0, 1);
    chk_u(0, mk(0, 0, ERR_NONE, 4'hD, 4'h2, 24'h0), 1);
    // Units ended by semicolons right after a keyword, a query mark or too few common letters
    run("VOLT?;LEV;VOLTA;*RS;OUTP\n", 1'b0, 5);
    chk_u(0, mk(0, 1, ERR_NONE, 4'h3, 4'h0, 24'h0), 1);
    chk_u(1, mk(0, 0, ERR_PATH, 4'h0, 4'h0, 24'h0), 0);
    chk_u(2, mk(0, 0, ERR_HEADER, 4'h0, 4'h0, 24'h0), 0);
    chk_u(3, mk(0, 0, ERR_SYNTAX, 4'h0, 4'h0, 24'h0), 0);
    chk_u(4, mk(0, 0, ERR_NONE, 4'hC, 4'h0, 24'h0), 1);
    $display("t_query done");
  endtask

  task automatic t_common();
    run("VOLT:LEV 1;*RST;PROT 2\n", 1'b0, 3);
    chk_u(1, mk(1, 0, ERR_NONE, 4'h0, 4'h0, 24'h52_5354), 1);
    chk("path", 4'h3, path_q[1]);
    chk_u(2, mk(0, 0, ERR_NONE, 4'hB, 4'h1, 24'h0), 1);
    run("*IDN?", 1'b1, 1);
    chk_u(0, mk(1, 1, ERR_NONE, 4'h0, 4'h0, 24'h49_444E), 1);
    $display("t_common done");
  endtask

  task automatic t_qint();
    u_host.set_pend(1'b1);
    run("VOLT?\n", 1'b0, 1);
    u_host.set_pend(1'b0);
    chk("qint", 1, n_qint);
    run("VOLT 2\n", 1'b0, 1);
    chk("qint", 1, n_qint);
    $display("t_qint done");
  endtask

  // ----------------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------------
  task automatic finish_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge clk_in);
    chk("reset", 36'h0, {uv, qint, flush, po});
    nrst_in = 1'b1;
    t_chain();
    t_root();
    t_spell();
    t_query();
    t_common();
    t_qint();
    finish_test();
  end
endmodule // scpi_message_parser_tb_top

// ===== verif/smp_host.sv
// Host controller model streaming command messages into the parser
`timescale 1ns/1ps
module smp_host (
  input wire logic clk_in,
  output logic [7:0] char_out,
  output logic valid_out,
  output logic eoi_out,
  output logic pend_out
);
  // ----------------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------------
  initial begin
    char_out = 8'h00;
    valid_out = 1'b0;
    eoi_out = 1'b0;
    pend_out = 1'b0;
  end

  // Unread reply flag; raising it before a message is a deliberate fault
  task automatic set_pend(input logic p);
    @(negedge clk_in);
    pend_out = p;
  endtask

  // One character per clock, back to back; no notation characters sent
  task automatic send(input string s, input bit with_eoi);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clk_in);
      char_out = s[i];
      valid_out = 1'b1;
      eoi_out = with_eoi && (i == s.len() - 1);
    end
    @(negedge clk_in);
    valid_out = 1'b0;
    eoi_out = 1'b0;
    // Released line shows the inverse, so a stale value is never trusted
    char_out = ~char_out;
  endtask
endmodule // smp_host
